// File: include/auth_ctl_pkg.sv
// Package: constants and carrier types for the cipher authentication control
`default_nettype none
package auth_ctl_pkg;
    localparam int KEY_BITS     = 48;
    localparam int KEY_FIFO_BYTES = 12;
    localparam int NVM_ARG_BYTES  = 2;
    localparam int NVM_ADDR_BITS  = 9;
    localparam int PASS_COUNT   = 3;
    localparam logic [47:0] KEY_RESET = 48'h000000000000;

    // Commands the host can start
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_KEY_NVM,
        CMD_KEY_FIFO,
        CMD_AUTH1,
        CMD_AUTH2
    } cmd_t;

    // Command request from the host side
    typedef struct packed {
        logic start;
        cmd_t cmd;
    } cmd_req_t;

    // Exchange with the card transceiver engine
    typedef struct packed {
        logic       start;
        logic       pass2;
        logic [47:0] key;
    } xcv_req_t;

    // Status returned to the host
    typedef struct packed {
        logic done;
        logic key_format_error_flag;
        logic auth_error;
        logic cipher_active_bit;
    } status_t;
endpackage : auth_ctl_pkg
`default_nettype wire

// File: hw/key_buffer.sv
// Key buffer: holds the 48-bit cipher key, registered read data
`default_nettype none
module key_buffer #(
    parameter int WIDTH = auth_ctl_pkg::KEY_BITS
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] rd_data
);
    typedef struct packed {
        logic [WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } kb_state_t;

    kb_state_t s_q;
    kb_state_t s_d;

    // Only the cipher key length is served
    if (WIDTH != auth_ctl_pkg::KEY_BITS) begin : g_bad_width
        $error("key buffer width must match cipher key length");
    end

    // Contents change only on a key-load write
    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.mem = wr_data;
        end
        s_d.rd = s_d.mem; // Write-through: new key readable one edge on
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
endmodule : key_buffer
`default_nettype wire

// File: hw/stream_cipher_auth_control.sv
// Authentication sequencer and key loading for the stream cipher unit
`default_nettype none
module stream_cipher_auth_control (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire auth_ctl_pkg::cmd_req_t  cmd_req,
    input  wire logic                    host_clear_cipher,
    input  wire logic                    fifo_valid,
    input  wire logic [7:0]              fifo_data,
    output logic                         fifo_pop,
    output logic                         nvm_rd,
    output logic [8:0]                   nvm_addr,
    input  wire logic                    nvm_valid,
    input  wire logic [7:0]              nvm_data,
    output auth_ctl_pkg::xcv_req_t       xcv_req,
    input  wire logic                    xcv_done,
    input  wire logic                    xcv_ok,
    output logic                         cipher_init,
    output logic                         encrypt_en,
    output auth_ctl_pkg::status_t        status
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARGS, ST_NVM_RD, ST_KEY_FIFO, ST_CHECK, ST_AUTH
    } state_t;

    typedef struct packed {
        state_t         st;
        auth_ctl_pkg::cmd_t cmd;
        logic [3:0]     cnt;
        logic [95:0]    raw;
        logic [8:0]     addr;
        logic           auth1_ok;
        logic           kb_wr;
        logic [47:0]    kb_data;
        logic           fifo_pop;
        logic           nvm_rd;
        auth_ctl_pkg::xcv_req_t xcv;
        logic           init;
        auth_ctl_pkg::status_t stat;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic [47:0] key_rd;

    // Stored key byte k is followed by its bitwise complement
    function automatic logic fmt_ok(input logic [95:0] r);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (r[i*16 +: 8] != ~r[i*16+8 +: 8]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : fmt_ok

    function automatic logic [47:0] fmt_key(input logic [95:0] r);
        logic [47:0] k;
        k = '0;
        for (int i = 0; i < 6; i++) begin
            k[i*8 +: 8] = r[i*16 +: 8];
        end
        return k;
    endfunction : fmt_key

    // Key storage lives in its own module; auth still registers key copies in kb_data and xcv.key
    key_buffer #(
        .WIDTH   (auth_ctl_pkg::KEY_BITS)
    ) u_key_buffer (
        .clk     (clk),
        .rst_b   (rst_b),
        // Written from the next state, so a command taken right after
        // done already reads the new key rather than the old one
        .wr_en   (s_d.kb_wr),
        .wr_data (s_d.kb_data),
        .rd_data (key_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_comb begin
        s_d = s_q;
        s_d.kb_wr = 1'b0;
        s_d.fifo_pop = 1'b0;
        s_d.nvm_rd = 1'b0;
        s_d.xcv.start = 1'b0;
        s_d.init = 1'b0;
        s_d.stat.done = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (cmd_req.start) begin
                    s_d.cmd = cmd_req.cmd;
                    s_d.cnt = '0;
                    // A command other than second auth breaks the pairing
                    if (cmd_req.cmd != auth_ctl_pkg::CMD_AUTH2) begin
                        s_d.auth1_ok = 1'b0;
                    end
                    unique case (cmd_req.cmd)
                        auth_ctl_pkg::CMD_KEY_NVM:  s_d.st = ST_ARGS;
                        auth_ctl_pkg::CMD_KEY_FIFO: begin
                            s_d.st = ST_KEY_FIFO;
                            s_d.stat.key_format_error_flag = 1'b0;
                        end
                        auth_ctl_pkg::CMD_AUTH1, auth_ctl_pkg::CMD_AUTH2: begin
                            // Key always from buffer, no selector
                            s_d.xcv.key = key_rd;
                            s_d.xcv.pass2 =
                                (cmd_req.cmd == auth_ctl_pkg::CMD_AUTH2);
                            s_d.xcv.start = 1'b1;
                            s_d.init =
                                (cmd_req.cmd == auth_ctl_pkg::CMD_AUTH1);
                            s_d.stat.auth_error = 1'b0;
                            s_d.st = ST_AUTH;
                        end
                        default: s_d.stat.done = 1'b1;
                    endcase
                end
            end
            ST_ARGS: begin
                // Wait for both start-address bytes in the FIFO
                if (fifo_valid && !s_q.fifo_pop) begin
                    s_d.fifo_pop = 1'b1;
                    s_d.addr = {s_q.addr[0], fifo_data};
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (s_q.cnt == 4'(auth_ctl_pkg::NVM_ARG_BYTES - 1)) begin
                        s_d.cnt = '0;
                        s_d.stat.key_format_error_flag = 1'b0;
                        s_d.nvm_rd = 1'b1;
                        s_d.st = ST_NVM_RD;
                    end
                end
            end
            ST_NVM_RD: begin
                if (nvm_valid) begin
                    s_d.raw = {nvm_data, s_q.raw[95:8]};
                    s_d.addr = s_q.addr + 9'h001;
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (s_q.cnt == 4'(auth_ctl_pkg::KEY_FIFO_BYTES - 1)) begin
                        s_d.st = ST_CHECK;
                    end else begin
                        s_d.nvm_rd = 1'b1;
                    end
                end
            end
            ST_KEY_FIFO: begin
                // Twelve FIFO bytes form the key
                if (fifo_valid && !s_q.fifo_pop) begin
                    s_d.fifo_pop = 1'b1;
                    s_d.raw = {fifo_data, s_q.raw[95:8]};
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (s_q.cnt == 4'(auth_ctl_pkg::KEY_FIFO_BYTES - 1)) begin
                        s_d.st = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                // Bad format still writes (undefined) key and flags it
                s_d.kb_wr = 1'b1;
                s_d.kb_data = fmt_key(s_q.raw);
                if (!fmt_ok(s_q.raw)) begin
                    s_d.stat.key_format_error_flag = 1'b1;
                end
                s_d.stat.done = 1'b1;
                s_d.st = ST_IDLE;
            end
            ST_AUTH: begin
                if (xcv_done) begin
                    s_d.stat.done = 1'b1;
                    s_d.stat.auth_error = !xcv_ok;
                    if (s_q.cmd == auth_ctl_pkg::CMD_AUTH1) begin
                        s_d.auth1_ok = xcv_ok;
                    end else begin
                        // Success needs a good first pass just before
                        s_d.stat.cipher_active_bit = xcv_ok && s_q.auth1_ok;
                        s_d.stat.auth_error = !(xcv_ok && s_q.auth1_ok);
                        s_d.auth1_ok = 1'b0;
                    end
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // Host may clear but never set; hardware set wins
        if (host_clear_cipher && !(s_q.st == ST_AUTH && xcv_done &&
            s_q.cmd == auth_ctl_pkg::CMD_AUTH2 && xcv_ok && s_q.auth1_ok)) begin
            s_d.stat.cipher_active_bit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign fifo_pop    = s_q.fifo_pop;
    assign nvm_rd      = s_q.nvm_rd;
    assign nvm_addr    = s_q.addr;
    assign xcv_req     = s_q.xcv;
    assign cipher_init = s_q.init;
    assign encrypt_en  = s_q.stat.cipher_active_bit;
    assign status      = s_q.stat;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_init_first;
        @(posedge clk) disable iff (!rst_b)
        (s_q.xcv.start && !s_q.xcv.pass2) |-> cipher_init;
    endproperty
    a_init_first: assert property (p_init_first)
        else $error("first auth did not initialise cipher");

    property p_no_set_idle;
        @(posedge clk) disable iff (!rst_b)
        $rose(status.cipher_active_bit) |->
            ($past(s_q.st) == ST_AUTH &&
             $past(s_q.cmd) == auth_ctl_pkg::CMD_AUTH2);
    endproperty
    a_no_set_idle: assert property (p_no_set_idle)
        else $error("cipher active set outside second auth");

    property p_key_hold;
        @(posedge clk) disable iff (!rst_b)
        (s_q.st == ST_AUTH) |=> $stable(key_rd);
    endproperty
    a_key_hold: assert property (p_key_hold)
        else $error("key changed during authentication");

    property p_enc;
        @(posedge clk) disable iff (!rst_b)
        $rose(encrypt_en) |->
            ($past(xcv_done) && $past(xcv_ok) && $past(s_q.auth1_ok));
    endproperty
    a_enc: assert property (p_enc)
        else $error("encryption started without a good second auth");

    property p_fail_clears;
        @(posedge clk) disable iff (!rst_b)
        (s_q.st == ST_AUTH && xcv_done && !xcv_ok &&
         s_q.cmd == auth_ctl_pkg::CMD_AUTH2) |=> !encrypt_en;
    endproperty
    a_fail_clears: assert property (p_fail_clears)
        else $error("failed second auth left cipher active");

    property p_host_clear;
        @(posedge clk) disable iff (!rst_b)
        (host_clear_cipher && s_q.st != ST_AUTH) |=>
            !status.cipher_active_bit;
    endproperty
    a_host_clear: assert property (p_host_clear)
        else $error("host clear did not drop cipher active");

    // Pop then wait keeps the FIFO head settled between takes
    property p_pop_spacing;
        @(posedge clk) disable iff (!rst_b)
        fifo_pop |=> !fifo_pop;
    endproperty
    a_pop_spacing: assert property (p_pop_spacing)
        else $error("fifo popped on back-to-back cycles");

    property p_key_write;
        @(posedge clk) disable iff (!rst_b)
        s_q.kb_wr |-> key_rd == s_q.kb_data;
    endproperty
    a_key_write: assert property (p_key_write)
        else $error("loaded key not visible in key buffer");

    property p_key_only_load;
        @(posedge clk) disable iff (!rst_b)
        $changed(key_rd) |-> s_q.kb_wr;
    endproperty
    a_key_only_load: assert property (p_key_only_load)
        else $error("key buffer changed without a key load");
endmodule : stream_cipher_auth_control
`default_nettype wire

// File: dv/card_model.sv
// Card-side model that answers the authentication passes over the link
`default_nettype none
module card_model (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire auth_ctl_pkg::xcv_req_t xcv_req,
    input  wire logic [47:0]            card_key,
    input  wire logic                   slow,
    output logic                        xcv_done,
    output logic                        xcv_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt;
    logic p1_q;
    logic p2_q;
    logic ok_q;
    // A wrong key, or a second pass without a good first, fails the card
    // ok toggles between answers so a stale value is never trusted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            p1_q <= 1'b0;
            p2_q <= 1'b0;
            ok_q <= 1'b0;
            xcv_done <= 1'b0;
            xcv_ok <= 1'b0;
        end else if (xcv_req.start) begin
            cnt <= slow ? 20 : 1;
            p2_q <= xcv_req.pass2;
            ok_q <= (xcv_req.key == card_key) &&
                    (!xcv_req.pass2 || p1_q);
            xcv_done <= 1'b0;
        end else if (cnt == 1) begin
            cnt <= 0;
            xcv_done <= 1'b1;
            xcv_ok <= ok_q;
            p1_q <= ok_q && !p2_q;
        end else begin
            if (cnt > 0) cnt <= cnt - 1;
            xcv_done <= 1'b0;
            xcv_ok <= ~xcv_ok;
        end
    end
endmodule : card_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the authentication sequencer and key loads
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, hclr, fifo_valid, fifo_pop, nvm_rd, nvm_valid;
    logic xcv_done, xcv_ok, cipher_init, encrypt_en, slow, s_init, s_p2;
    logic [7:0] fifo_data, nvm_data, fq[$];
    logic [8:0] nvm_addr, a0;
    logic [47:0] card_key, s_key, kn;
    auth_ctl_pkg::cmd_req_t cmd_req;
    auth_ctl_pkg::xcv_req_t xcv_req;
    auth_ctl_pkg::status_t  status;
    int mismatches, tests_run, nrd;
    stream_cipher_auth_control u_dut (.clk(clk), .rst_b(rst_b),
        .cmd_req(cmd_req), .host_clear_cipher(hclr),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_pop(fifo_pop),
        .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_valid(nvm_valid),
        .nvm_data(nvm_data), .xcv_req(xcv_req), .xcv_done(xcv_done),
        .xcv_ok(xcv_ok), .cipher_init(cipher_init), .encrypt_en(encrypt_en),
        .status(status));
    card_model u_card (.clk(clk), .rst_b(rst_b), .xcv_req(xcv_req),
        .card_key(card_key), .slow(slow), .xcv_done(xcv_done),
        .xcv_ok(xcv_ok));
    ////////////////////////////////////////////////////////////////////
    // Key bytes in memory come as byte/complement pairs
    function automatic logic [7:0] nvf(input logic [8:0] a);
        logic [7:0] k;
        k = {a[7:1], 1'b0} ^ 8'h5A;
        return a[0] ? ~k : k;
    endfunction : nvf
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // FIFO head, memory answers and a record of each card request
    always @(negedge clk) begin
        if (fifo_pop && fq.size() > 0) fq.pop_front();
        fifo_valid = fq.size() > 0;
        fifo_data = (fq.size() > 0) ? fq[0] : ~fifo_data;
        nvm_valid = nvm_rd;
        nvm_data = nvm_rd ? nvf(nvm_addr) : ~nvm_data;
    end
    always @(posedge clk) begin
        if (xcv_req.start) begin
            s_key <= xcv_req.key;
            s_init <= cipher_init;
            s_p2 <= xcv_req.pass2;
        end
        if (nvm_rd) begin
            if (nrd == 0) a0 <= nvm_addr;
            nrd <= nrd + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    // One-cycle start, then a bounded wait for the done pulse
    task automatic run(input auth_ctl_pkg::cmd_t c);
        int n;
        @(negedge clk) cmd_req = '{1'b1, c};
        @(negedge clk) cmd_req.start = 1'b0;
        for (n = 0; n < 300 && status.done !== 1'b1; n++) @(posedge clk) #1;
        chk(status.done, 1'b1);
    endtask : run
    task automatic fkey(input logic [47:0] k, input logic bad);
        for (int i = 0; i < 6; i++) begin
            fq.push_back(k[8*i+:8]);
            fq.push_back(~k[8*i+:8] ^ {7'h00, bad && i == 3});
        end
        run(auth_ctl_pkg::CMD_KEY_FIFO);
        chk(status.key_format_error_flag, bad);
        chk(fq.size(), 0);
    endtask : fkey
    task automatic au(input auth_ctl_pkg::cmd_t c, input logic [47:0] k,
                      input logic ok, input logic on);
        logic p2;
        p2 = (c == auth_ctl_pkg::CMD_AUTH2);
        run(c);
        chk(s_key, k);
        chk(s_init, !p2);
        chk(s_p2, p2);
        chk(status.auth_error, !ok);
        if (p2) chk(status.cipher_active_bit, on);
        if (p2) chk(encrypt_en, on);
    endtask : au
    task automatic t_clear();
        @(negedge clk) hclr = 1'b1;
        @(negedge clk) hclr = 1'b0;
        @(negedge clk) chk(status.cipher_active_bit, 1'b0);
        chk(encrypt_en, 1'b0);
    endtask : t_clear
    task automatic t_nvm();
        fq.push_back(8'h00);
        fq.push_back(8'h10);
        nrd = 0;
        run(auth_ctl_pkg::CMD_KEY_NVM);
        chk(nrd, 12);
        chk(a0, 9'h010);
        chk(status.key_format_error_flag, 1'b0);
    endtask : t_nvm
    // Every output at rest, as after reset
    task automatic chk_idle();
        chk(status, '0);
        chk({encrypt_en, cipher_init, fifo_pop, nvm_rd}, '0);
        chk({xcv_req.start, xcv_req.pass2, nvm_addr}, '0);
        chk(xcv_req.key, '0);
    endtask : chk_idle
    // Hardware set beats a host clear held through the second pass
    task automatic t_set_wins();
        au(auth_ctl_pkg::CMD_AUTH1, kn, 1'b1, 1'b0);
        @(negedge clk) hclr = 1'b1;
        au(auth_ctl_pkg::CMD_AUTH2, kn, 1'b1, 1'b1);
        @(posedge clk) #1;
        chk(status.cipher_active_bit, 1'b0);
        @(negedge clk) hclr = 1'b0;
    endtask : t_set_wins
    // Any command between the passes voids the first, though the card agrees
    task automatic t_pair();
        au(auth_ctl_pkg::CMD_AUTH1, kn, 1'b1, 1'b0);
        run(auth_ctl_pkg::CMD_NONE);
        au(auth_ctl_pkg::CMD_AUTH2, kn, 1'b0, 1'b0);
    endtask : t_pair
    // Reset mid-run empties the key buffer, so the card then refuses
    task automatic t_reset();
        @(negedge clk) rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk_idle();
        rst_b = 1'b1;
        au(auth_ctl_pkg::CMD_AUTH1, 48'h0, 1'b0, 1'b0);
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    // Load, authenticate, clear, reload from memory, then a failing pass
    initial begin
        {rst_b, hclr, slow, nvm_valid, fifo_valid} = '0;
        {fifo_data, nvm_data, nrd, mismatches, tests_run} = '0;
        cmd_req = '0;
        card_key = 48'hC3A51E0F7796;
        for (int i = 0; i < 6; i++) kn[8*i+:8] = (8'h10 + 2 * i) ^ 8'h5A;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        chk_idle();
        fkey(card_key, 1'b0);
        au(auth_ctl_pkg::CMD_AUTH1, card_key, 1'b1, 1'b0);
        slow = 1'b1;
        au(auth_ctl_pkg::CMD_AUTH2, card_key, 1'b1, 1'b1);
        t_clear();
        au(auth_ctl_pkg::CMD_AUTH1, card_key, 1'b1, 1'b0);
        fkey(48'h0123456789AB, 1'b1);
        card_key = kn;
        t_nvm();
        au(auth_ctl_pkg::CMD_AUTH1, kn, 1'b1, 1'b0);
        slow = 1'b0;
        au(auth_ctl_pkg::CMD_AUTH2, kn, 1'b1, 1'b1);
        card_key = ~kn;
        au(auth_ctl_pkg::CMD_AUTH1, kn, 1'b0, 1'b1);
        au(auth_ctl_pkg::CMD_AUTH2, kn, 1'b0, 1'b0);
        card_key = kn;
        t_set_wins();
        t_pair();
        t_reset();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
